// File: design/tom_pkg.sv
// package: register map, fields and encodings of the offset and config bank
package tom_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] ADDR_LOCAL_OFS = 8'h71;
	localparam logic [7:0] ADDR_REMOTE2_OFS = 8'h72;
	localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
	localparam logic [7:0] ADDR_CONTROL = 8'h80;
	localparam logic [7:0] ADDR_DUTY_BASE = 8'h84;
	// reset values
	localparam logic [7:0] RST_LOCAL_OFS = 8'h00;
	localparam logic [7:0] RST_REMOTE2_OFS = 8'h00;
	localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
	localparam logic [7:0] DUTY_SHUTDOWN = 8'h00;
	// config two fields
	localparam int BIT_SENSE_EN = 0;
	localparam int BIT_FLAG_LO = 1;
	localparam int BIT_AVG_BYP = 4;
	localparam int BIT_ATTENUATOR_BYPASS_BYP = 5;
	localparam int BIT_SINGLE = 6;
	localparam int BIT_SHUTDOWN_ENABLE = 7;
	// writable mask of config two
	localparam logic [7:0] CFG2_WMASK = 8'hf1;
	// control register fields (lock and polarity)
	localparam int BIT_LOCK = 0;
	localparam int BIT_INVERT = 1;
	// channel select field in the speed-min high byte
	localparam int CHSEL_LSB = 5;
	// channel codes
	typedef enum logic [2:0] {
		TOM_CH_RSV0 = 3'h0,
		TOM_CH_CORE = 3'h1,
		TOM_CH_SUPPLY = 3'h2,
		TOM_CH_RSV3 = 3'h3,
		TOM_CH_RSV4 = 3'h4,
		TOM_CH_REMOTE1 = 3'h5,
		TOM_CH_LOCAL = 3'h6,
		TOM_CH_REMOTE2 = 3'h7
	} tom_chan_t;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: design/tom_offset_add.sv
// saturating add of a half-degree signed offset to a 10-bit reading
module tom_offset_add (
	// reading, quarter-degree lsb
	input wire logic [9:0] i_raw,
	// offset, half-degree lsb
	input wire logic [7:0] i_ofs,
	// corrected reading
	output logic [9:0] o_sum
);
	logic signed [11:0] sum;
	always_comb begin
		sum = $signed({2'h0, i_raw}) + $signed({{3{i_ofs[7]}}, i_ofs, 1'b0});
		if (sum < 0) begin
			o_sum = 10'h000;
		end else if (sum > 12'sh3ff) begin
			o_sum = 10'h3ff;
		end else begin
			o_sum = sum[9:0];
		end
	end
endmodule

// File: design/tom_regs.sv
// offset correction and measurement config two register bank, axi4-lite slave
// Notes on behaviour
// - local offset added, half degree per count
// - remote two offset added, half degree per count
// - offsets and config two reset zero
// - lock bit makes these registers read-only
// - sense enable makes bits 3:1 show fans
// - bits 3:1 read-only four-wire flags
// - bit 4 skips conversion averaging
// - bit 5 bypasses core voltage attenuator
// - bit 6 converts one selected channel
// - channel from bits 7:5 of 0x55
// - bit 7 forces fan drives off
// - shutdown duty reads return zero
module tom_regs (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// axi4-lite write address
	input wire logic [9:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	// axi4-lite write data
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// axi4-lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read address
	input wire logic [9:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	// axi4-lite read data
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// measurement side
	input wire logic [9:0] i_local_raw,
	input wire logic [9:0] i_remote2_raw,
	input wire logic i_meas_done,
	input wire logic [2:0] i_fan_detect,
	input wire logic [7:0] i_speed_min_hi,
	input wire logic [23:0] i_duty_cur,
	input wire logic [2:0] i_pwm_raw,
	// measurement controls and results
	output logic [9:0] o_local_temp,
	output logic [9:0] o_remote2_temp,
	output logic o_averaging_bypass,
	output logic o_attenuator_bypass,
	output logic o_single_channel_convert,
	output logic [2:0] o_chan_sel,
	output logic o_convert_enable,
	output logic o_shutdown_enable,
	output logic [2:0] o_pwm
);
	typedef struct packed {
		logic aw_got;
		logic [9:0] aw_addr;
		logic w_got;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] local_ofs;
		logic [7:0] remote2_ofs;
		logic [7:0] cfg2;
		logic [1:0] ctrl;
		logic [2:0] det_m;
		logic [2:0] det_s;
		logic [2:0] pwm_m;
		logic [2:0] pwm_s;
		logic [9:0] local_t;
		logic [9:0] remote2_t;
		logic single_channel_convert_en;
		logic [2:0] pwm;
		logic [2:0] chan_sel;
	} tom_state_t;

	tom_state_t st_r;
	tom_state_t st_nxt;
	logic [9:0] local_sum;
	logic [9:0] remote2_sum;
	logic [7:0] cfg2_view;
	logic chan_ok;
	logic [2:0] chan;
	// write decode
	logic wr_fire;
	logic wr_locked;
	logic wr_lane0;
	logic [7:0] wr_idx;
	logic wr_hit_local;
	logic wr_hit_remote2;
	logic wr_hit_cfg2;
	logic wr_hit_ctrl;
	logic wr_hit_duty;
	logic wr_mapped;
	logic [7:0] cfg2_wr;
	// read decode
	logic rd_fire;
	logic [7:0] rd_idx;
	logic rd_hit_local;
	logic rd_hit_remote2;
	logic rd_hit_cfg2;
	logic rd_hit_ctrl;
	logic rd_hit_duty;
	logic rd_mapped;
	logic [23:0] duty_view;

	tom_offset_add u_local_add (
		.i_raw(i_local_raw),
		.i_ofs(st_r.local_ofs),
		.o_sum(local_sum)
	);
	tom_offset_add u_remote2_add (
		.i_raw(i_remote2_raw),
		.i_ofs(st_r.remote2_ofs),
		.o_sum(remote2_sum)
	);

	always_comb begin
		st_nxt = st_r;
		chan = i_speed_min_hi[tom_pkg::CHSEL_LSB +: 3];
		st_nxt.chan_sel = chan;
		case (chan)
			tom_pkg::TOM_CH_CORE,
			tom_pkg::TOM_CH_SUPPLY,
			tom_pkg::TOM_CH_REMOTE1,
			tom_pkg::TOM_CH_LOCAL,
			tom_pkg::TOM_CH_REMOTE2: chan_ok = 1'b1;
			default: chan_ok = 1'b0;
		endcase
		// flag view of config two
		cfg2_view = st_r.cfg2;
		if (st_r.cfg2[tom_pkg::BIT_SENSE_EN]) begin
			cfg2_view[tom_pkg::BIT_FLAG_LO +: 3] = st_r.det_s;
		end else begin
			cfg2_view[tom_pkg::BIT_FLAG_LO +: 3] = 3'h0;
		end
		// pin synchronisers
		st_nxt.det_m = i_fan_detect;
		st_nxt.det_s = st_r.det_m;
		st_nxt.pwm_m = i_pwm_raw;
		st_nxt.pwm_s = st_r.pwm_m;
		// conversion gating
		st_nxt.single_channel_convert_en = !(st_r.cfg2[tom_pkg::BIT_SINGLE] && !chan_ok);
		if (i_meas_done && st_r.single_channel_convert_en) begin
			st_nxt.local_t = local_sum;
			st_nxt.remote2_t = remote2_sum;
		end
		// fan drive, forced off in shutdown
		if (st_r.cfg2[tom_pkg::BIT_SHUTDOWN_ENABLE]) begin
			st_nxt.pwm = {3{st_r.ctrl[tom_pkg::BIT_INVERT]}};
		end else begin
			st_nxt.pwm = st_r.pwm_s;
		end
		// write channel
		if (!st_r.aw_got && i_awvalid) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.aw_addr = i_awaddr;
		end
		if (!st_r.w_got && i_wvalid) begin
			st_nxt.w_got = 1'b1;
			st_nxt.w_data = i_wdata[7:0];
			st_nxt.w_strb0 = i_wstrb[0];
		end
		// write decode, one word per register
		wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
		wr_idx = st_r.aw_addr[9:2];
		wr_locked = st_r.ctrl[tom_pkg::BIT_LOCK];
		wr_lane0 = st_r.w_strb0;
		wr_hit_local = (wr_idx == tom_pkg::ADDR_LOCAL_OFS);
		wr_hit_remote2 = (wr_idx == tom_pkg::ADDR_REMOTE2_OFS);
		wr_hit_cfg2 = (wr_idx == tom_pkg::ADDR_CONFIG_TWO);
		wr_hit_ctrl = (wr_idx == tom_pkg::ADDR_CONTROL);
		wr_hit_duty = (wr_idx == tom_pkg::ADDR_DUTY_BASE);
		wr_mapped = wr_hit_local || wr_hit_remote2 || wr_hit_cfg2 || wr_hit_ctrl || wr_hit_duty;
		// config two write value, flag bits kept clear
		cfg2_wr = st_r.w_data & tom_pkg::CFG2_WMASK;
		if (wr_fire) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			if (wr_mapped) begin
				st_nxt.bresp = tom_pkg::RESP_OKAY;
			end else begin
				st_nxt.bresp = tom_pkg::RESP_SLVERR;
			end
			if (wr_lane0 && !wr_locked) begin
				if (wr_hit_local) begin
					st_nxt.local_ofs = st_r.w_data;
				end
				if (wr_hit_remote2) begin
					st_nxt.remote2_ofs = st_r.w_data;
				end
				if (wr_hit_cfg2) begin
					st_nxt.cfg2 = cfg2_wr;
				end
			end
			if (wr_lane0 && wr_hit_ctrl) begin
				// lock is sticky until reset
				st_nxt.ctrl[tom_pkg::BIT_LOCK] = st_r.ctrl[tom_pkg::BIT_LOCK] |
					st_r.w_data[tom_pkg::BIT_LOCK];
				st_nxt.ctrl[tom_pkg::BIT_INVERT] = st_r.w_data[tom_pkg::BIT_INVERT];
			end
		end
		if (st_r.bvalid && i_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// read decode, one word per register
		rd_fire = i_arvalid && !st_r.rvalid;
		rd_idx = i_araddr[9:2];
		rd_hit_local = (rd_idx == tom_pkg::ADDR_LOCAL_OFS);
		rd_hit_remote2 = (rd_idx == tom_pkg::ADDR_REMOTE2_OFS);
		rd_hit_cfg2 = (rd_idx == tom_pkg::ADDR_CONFIG_TWO);
		rd_hit_ctrl = (rd_idx == tom_pkg::ADDR_CONTROL);
		rd_hit_duty = (rd_idx == tom_pkg::ADDR_DUTY_BASE);
		rd_mapped = rd_hit_local || rd_hit_remote2 || rd_hit_cfg2 || rd_hit_ctrl || rd_hit_duty;
		// duty view, zero while shut down
		if (st_r.cfg2[tom_pkg::BIT_SHUTDOWN_ENABLE]) begin
			duty_view = {3{tom_pkg::DUTY_SHUTDOWN}};
		end else begin
			duty_view = i_duty_cur;
		end
		// read channel
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = 32'h0000_0000;
			if (rd_mapped) begin
				st_nxt.rresp = tom_pkg::RESP_OKAY;
			end else begin
				st_nxt.rresp = tom_pkg::RESP_SLVERR;
			end
			if (rd_hit_local) begin
				st_nxt.rdata = {24'h00_0000, st_r.local_ofs};
			end
			if (rd_hit_remote2) begin
				st_nxt.rdata = {24'h00_0000, st_r.remote2_ofs};
			end
			if (rd_hit_cfg2) begin
				st_nxt.rdata = {24'h00_0000, cfg2_view};
			end
			if (rd_hit_ctrl) begin
				st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
			end
			if (rd_hit_duty) begin
				st_nxt.rdata = {8'h00, duty_view};
			end
		end else if (st_r.rvalid && i_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.local_ofs <= tom_pkg::RST_LOCAL_OFS;
			st_r.remote2_ofs <= tom_pkg::RST_REMOTE2_OFS;
			st_r.cfg2 <= tom_pkg::RST_CONFIG_TWO;
			st_r.single_channel_convert_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	assign o_awready = !st_r.aw_got;
	assign o_wready = !st_r.w_got;
	assign o_bvalid = st_r.bvalid;
	assign o_bresp = st_r.bresp;
	assign o_arready = !st_r.rvalid;
	assign o_rvalid = st_r.rvalid;
	assign o_rdata = st_r.rdata;
	assign o_rresp = st_r.rresp;
	assign o_local_temp = st_r.local_t;
	assign o_remote2_temp = st_r.remote2_t;
	assign o_averaging_bypass = st_r.cfg2[tom_pkg::BIT_AVG_BYP];
	assign o_attenuator_bypass = st_r.cfg2[tom_pkg::BIT_ATTENUATOR_BYPASS_BYP];
	assign o_single_channel_convert = st_r.cfg2[tom_pkg::BIT_SINGLE];
	assign o_chan_sel = st_r.chan_sel;
	assign o_convert_enable = st_r.single_channel_convert_en;
	assign o_shutdown_enable = st_r.cfg2[tom_pkg::BIT_SHUTDOWN_ENABLE];
	assign o_pwm = st_r.pwm;
endmodule

// File: tb/tom_regs_props.sv
// assertions on the offset and config two bank ports
module tom_regs_props (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// bus handshakes
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	// measurement controls
	input wire logic [7:0] i_speed_min_hi,
	input wire logic [2:0] o_chan_sel,
	input wire logic o_single_channel_convert,
	input wire logic o_convert_enable,
	input wire logic o_shutdown_enable,
	input wire logic [2:0] o_pwm
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rst;
		$rose(i_rst_n) |-> !o_shutdown_enable && !o_single_channel_convert && o_convert_enable;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_bresp;
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write answer late");
	property p_rresp;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	a_rresp: assert property (p_rresp) else $error("read answer late");
	property p_bhold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_chsel;
		$stable(i_speed_min_hi) [*2] |-> o_chan_sel == i_speed_min_hi[7:5];
	endproperty
	a_chsel: assert property (p_chsel) else $error("channel select wrong");
	property p_rsv;
		(o_single_channel_convert && o_chan_sel inside {3'h0, 3'h3, 3'h4}) [*2]
			|-> !o_convert_enable;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code converts");
	property p_scan;
		(!o_single_channel_convert) [*2] |-> o_convert_enable;
	endproperty
	a_scan: assert property (p_scan) else $error("scan stopped");
	property p_shutdown_enable;
		o_shutdown_enable [*2] |-> o_pwm == 3'h0 || o_pwm == 3'h7;
	endproperty
	a_shutdown_enable: assert property (p_shutdown_enable) else $error("drive not off");
	c_shutdown_enable: cover property (o_shutdown_enable && o_pwm == 3'h7);
	c_rsv: cover property (o_single_channel_convert && !o_convert_enable);
	c_wr: cover property (o_bvalid && i_bready);
endmodule

// File: tb/temp_offset_and_meas_config_tb.sv
// testbench for the offset and config two register bank
module temp_offset_and_meas_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_meas_done = 1'h0;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
	logic [9:0] i_awaddr = 10'h0, i_araddr = 10'h0;
	logic [7:0] i_speed_min_hi = 8'h0;
	localparam logic [9:0] addr_loc = {tom_pkg::ADDR_LOCAL_OFS, 2'h0};
	localparam logic [9:0] addr_rem = {tom_pkg::ADDR_REMOTE2_OFS, 2'h0};
	localparam logic [9:0] addr_cfg = {tom_pkg::ADDR_CONFIG_TWO, 2'h0};
	localparam logic [9:0] addr_ctl = {tom_pkg::ADDR_CONTROL, 2'h0};
	localparam logic [9:0] addr_duty = {tom_pkg::ADDR_DUTY_BASE, 2'h0};
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic [9:0] i_local_raw = 10'h0, i_remote2_raw = 10'h0, exp_loc;
	logic [2:0] i_fan_detect = 3'h5, i_pwm_raw = 3'h5, o_chan_sel, o_pwm;
	logic [23:0] i_duty_cur = 24'h123456;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_convert_enable;
	logic o_averaging_bypass, o_attenuator_bypass, o_single_channel_convert, o_shutdown_enable;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [9:0] o_local_temp, o_remote2_temp;
	int miscompares = 0, n_tests = 0, c;
	tom_regs dut (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.i_local_raw(i_local_raw),
		.i_remote2_raw(i_remote2_raw),
		.i_meas_done(i_meas_done),
		.i_fan_detect(i_fan_detect),
		.i_speed_min_hi(i_speed_min_hi),
		.i_duty_cur(i_duty_cur),
		.i_pwm_raw(i_pwm_raw),
		.o_local_temp(o_local_temp),
		.o_remote2_temp(o_remote2_temp),
		.o_averaging_bypass(o_averaging_bypass),
		.o_attenuator_bypass(o_attenuator_bypass),
		.o_single_channel_convert(o_single_channel_convert),
		.o_chan_sel(o_chan_sel),
		.o_convert_enable(o_convert_enable),
		.o_shutdown_enable(o_shutdown_enable),
		.o_pwm(o_pwm)
	);
	always #4 i_core_clk = ~i_core_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge i_core_clk);
		i_awaddr <= a;
		i_wdata <= {24'h0, d};
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do begin
			@(posedge i_core_clk);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
		end while (o_bvalid !== 1'h1);
		i_bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, o_bresp});
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_core_clk);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do begin
			@(posedge i_core_clk);
			if (o_arready) i_arvalid <= 1'h0;
		end while (o_rvalid !== 1'h1);
		i_rready <= 1'h0;
		chk("rdata", e, o_rdata);
		chk("rresp", {30'h0, er}, {30'h0, o_rresp});
	endtask
	task automatic pulse;
		i_meas_done <= 1'h1;
		@(posedge i_core_clk);
		i_meas_done <= 1'h0;
		repeat (3) @(posedge i_core_clk);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_core_clk);
		miscompares++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst_n <= 1'h1;
		rd(addr_loc, 32'h0, 2'h0);
		rd(addr_rem, 32'h0, 2'h0);
		rd(addr_cfg, 32'h0, 2'h0);
		wr(addr_loc, 8'h04, 2'h0);
		wr(addr_rem, 8'hfe, 2'h0);
		rd(addr_loc, 32'h04, 2'h0);
		rd(addr_rem, 32'hfe, 2'h0);
		i_local_raw <= 10'h100;
		i_remote2_raw <= 10'h100;
		pulse;
		chk("local", 32'h108, {22'h0, o_local_temp});
		chk("remote2", 32'hfc, {22'h0, o_remote2_temp});
		i_remote2_raw <= 10'h2;
		pulse;
		chk("remote2", 32'h0, {22'h0, o_remote2_temp});
		wr(addr_cfg, 8'h01, 2'h0);
		repeat (4) @(posedge i_core_clk);
		rd(addr_cfg, 32'h0b, 2'h0);
		wr(addr_cfg, 8'h0e, 2'h0);
		rd(addr_cfg, 32'h00, 2'h0);
		wr(addr_cfg, 8'h70, 2'h0);
		chk("ctl", 32'h7, {29'h0, o_single_channel_convert, o_attenuator_bypass,
			o_averaging_bypass});
		exp_loc = 10'h108;
		for (c = 0; c < 8; c++) begin
			i_speed_min_hi <= {c[2:0], 5'h0};
			i_local_raw <= {c[2:0], 7'h0};
			repeat (3) @(posedge i_core_clk);
			if (!(c inside {0, 3, 4})) exp_loc = {c[2:0], 7'h0} + 10'h8;
			pulse;
			chk("chan", 32'(c), {29'h0, o_chan_sel});
			chk("enable", {31'h0, !(c inside {0, 3, 4})}, {31'h0, o_convert_enable});
			chk("local", {22'h0, exp_loc}, {22'h0, o_local_temp});
		end
		chk("pwm", 32'h5, {28'h0, o_shutdown_enable, o_pwm});
		rd(addr_duty, 32'h00123456, 2'h0);
		wr(addr_ctl, 8'h02, 2'h0);
		rd(addr_ctl, 32'h2, 2'h0);
		wr(addr_cfg, 8'h80, 2'h0);
		repeat (4) @(posedge i_core_clk);
		chk("pwm", 32'hf, {28'h0, o_shutdown_enable, o_pwm});
		rd(addr_duty, 32'h0, 2'h0);
		wr(addr_ctl, 8'h03, 2'h0);
		wr(addr_loc, 8'h11, 2'h0);
		wr(addr_cfg, 8'h00, 2'h0);
		rd(addr_cfg, 32'h80, 2'h0);
		rd(addr_loc, 32'h04, 2'h0);
		wr(10'h040, 8'h00, 2'h2);
		rd(10'h040, 32'h0, 2'h2);
		complete_run;
	end
endmodule
bind tom_regs tom_regs_props u_props (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_awvalid(i_awvalid),
	.o_awready(o_awready),
	.i_wvalid(i_wvalid),
	.o_wready(o_wready),
	.o_bresp(o_bresp),
	.o_bvalid(o_bvalid),
	.i_bready(i_bready),
	.i_arvalid(i_arvalid),
	.o_arready(o_arready),
	.o_rvalid(o_rvalid),
	.i_speed_min_hi(i_speed_min_hi),
	.o_chan_sel(o_chan_sel),
	.o_single_channel_convert(o_single_channel_convert),
	.o_convert_enable(o_convert_enable),
	.o_shutdown_enable(o_shutdown_enable),
	.o_pwm(o_pwm)
);
